// ---- rtl/rtc_lock_pkg.sv ----
// constants for the clock-calendar write lock and clock source logic
// assumes a 16-bit register port with word addresses and one system clock
package rtc_lock_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] A_CTRL1L = 4'h0;
  localparam logic [3:0] A_CTRL2L = 4'h1;
  localparam logic [3:0] A_CTRL2H = 4'h2;
  localparam logic [3:0] A_TIMEL = 4'h3;
  localparam logic [3:0] A_TIMEH = 4'h4;
  localparam logic [3:0] A_DATEL = 4'h5;
  localparam logic [3:0] A_DATEH = 4'h6;
  localparam logic [3:0] A_ALRMT = 4'h7;
  localparam logic [3:0] A_ALRMD = 4'h8;
  localparam logic [3:0] A_PWRC = 4'h9;
  localparam logic [3:0] A_TSTMT = 4'ha;
  localparam logic [3:0] A_TSTMD = 4'hb;
  localparam logic [3:0] A_KEY = 4'hc;
  localparam logic [3:0] A_STAT = 4'hd;
  localparam int BIT_EN = 15;
  localparam int BIT_LOCK = 11;
  localparam int STAT_ARMED = 1;
  localparam int STAT_OPEN = 0;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [1:0] SRC_SECONDARY = 2'h0;
  localparam logic [1:0] SRC_LOW_POWER_RC = 2'h1;
  localparam logic [1:0] SRC_LINE = 2'h2;
  localparam logic [1:0] SRC_SYS = 2'h3;
  localparam logic [15:0] RST_VALUE = 16'h0000;
  localparam logic RST_LOCK = 1'b0;
  localparam logic RST_EN = 1'b0;
  localparam int WIN_CYC = 1;
endpackage : rtc_lock_pkg

// ---- rtl/unlock_seq.sv ----
// two-write key detector that opens a one-cycle unlock window
// assumes write strobes decoded by the caller on the same clock
`timescale 1ns/10ps
module unlock_seq (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic key_wr_i,
  input wire logic other_wr_i,
  input wire logic [7:0] key_byte_i,
  output logic armed_o,
  output logic window_o
);
  typedef enum logic [1:0] {KEY_IDLE, KEY_ARMED, KEY_OPEN} key_state_e;
  key_state_e state_reg;
  key_state_e state_next;

  always_comb begin
    state_next = KEY_IDLE;
    case (state_reg)
      KEY_ARMED: begin
        if (key_wr_i && key_byte_i == rtc_lock_pkg::KEY_SECOND) begin
          state_next = KEY_OPEN;
        end else if (key_wr_i && key_byte_i == rtc_lock_pkg::KEY_FIRST) begin
          state_next = KEY_ARMED;
        end else if (key_wr_i || other_wr_i) begin
          state_next = KEY_IDLE;
        end else begin
          state_next = KEY_ARMED;
        end
      end
      default: begin
        // the open cycle lasts exactly one edge whatever happens
        if (key_wr_i && key_byte_i == rtc_lock_pkg::KEY_FIRST) begin
          state_next = KEY_ARMED;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= KEY_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign armed_o = (state_reg == KEY_ARMED);
  assign window_o = (state_reg == KEY_OPEN);

  chk_window_one_cycle: assert property (@(posedge mclk_i) disable iff (rst_i)
    window_o |=> !window_o)
    else $error("unlock window longer than one cycle");
  chk_window_after_pair: assert property (@(posedge mclk_i) disable iff (rst_i)
    (key_wr_i && key_byte_i == rtc_lock_pkg::KEY_FIRST)
    ##1 (key_wr_i && key_byte_i == rtc_lock_pkg::KEY_SECOND) |=> window_o)
    else $error("key pair did not open the window");
  chk_intervening_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    (armed_o && other_wr_i && !key_wr_i) |=> !armed_o && !window_o)
    else $error("other write did not disarm");
endmodule : unlock_seq

// ---- rtl/ref_clock_select.sv ----
// reference clock selection with pin synchronisers and rising-edge ticks
// assumes oscillator and powerline levels arrive asynchronously on pins
`timescale 1ns/10ps
module ref_clock_select (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [2:0] src_pins_i,
  input wire logic [1:0] clock_source_field_i,
  output logic ref_tick_o
);
  logic [2:0] rise_w;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      logic [2:0] sync_reg;
      logic filt_reg;
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          sync_reg <= 3'h0;
          filt_reg <= 1'b0;
        end else begin
          sync_reg <= {sync_reg[1:0], src_pins_i[g]};
          // change only once stages two and three agree
          if (sync_reg[1] == sync_reg[2]) begin
            filt_reg <= sync_reg[2];
          end
        end
      end
      assign rise_w[g] = (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !filt_reg;
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ref_tick_o <= 1'b0;
    end else begin
      case (clock_source_field_i)
        rtc_lock_pkg::SRC_SECONDARY: ref_tick_o <= rise_w[0];
        rtc_lock_pkg::SRC_LOW_POWER_RC: ref_tick_o <= rise_w[1];
        rtc_lock_pkg::SRC_LINE: ref_tick_o <= rise_w[2];
        default: ref_tick_o <= 1'b1;
      endcase
    end
  end

  chk_sysclk_tick: assert property (@(posedge mclk_i) disable iff (rst_i)
    clock_source_field_i == rtc_lock_pkg::SRC_SYS |=> ref_tick_o)
    else $error("system clock source did not tick");
  chk_secondary_tick: assert property (@(posedge mclk_i) disable iff (rst_i)
    clock_source_field_i == rtc_lock_pkg::SRC_SECONDARY |=> ref_tick_o == $past(rise_w[0]))
    else $error("secondary oscillator tick mismatch");
endmodule : ref_clock_select

// ---- rtl/rtc_write_lock_clock_select.sv ----
// write lock, unlock key and clock source selection for the clock-calendar
// assumes a single-master register port on mclk_i and same-clock reset causes
`timescale 1ns/10ps
module rtc_write_lock_clock_select (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic brownout_reset_i,
  input wire logic master_clear_reset_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [15:0] rd_data_o,
  input wire logic secondary_oscillator_i,
  input wire logic low_power_rc_oscillator_i,
  input wire logic powerline_i,
  output logic clock_calendar_enable_o,
  output logic write_lock_bit_o,
  output logic [1:0] clock_source_field_o,
  output logic ref_tick_o
);
  logic dev_rst;
  logic lock_reg;
  logic enable_reg;
  logic [15:0] val_reg [1:11];
  logic key_wr;
  logic other_wr;
  logic armed;
  logic window;
  logic ctrl1_wr;
  logic protect_hit;
  logic [15:0] rd_next;

  // every reset cause clears the same state; all are same-clock levels
  assign dev_rst = sys_rst_i || brownout_reset_i || master_clear_reset_i;

  assign key_wr = wr_en_i && (addr_i == rtc_lock_pkg::A_KEY);
  assign other_wr = wr_en_i && (addr_i != rtc_lock_pkg::A_KEY);
  assign ctrl1_wr = wr_en_i && (addr_i == rtc_lock_pkg::A_CTRL1L);
  assign protect_hit = (addr_i >= rtc_lock_pkg::A_CTRL2L) && (addr_i <= rtc_lock_pkg::A_DATEH);

  unlock_seq u_unlock (
    .mclk_i(mclk_i),
    .rst_i(dev_rst),
    .key_wr_i(key_wr),
    .other_wr_i(other_wr),
    .key_byte_i(wr_data_i[7:0]),
    .armed_o(armed),
    .window_o(window)
  );

  // lock bit: plain set, clear only inside the unlock window
  always_ff @(posedge mclk_i) begin
    if (dev_rst) begin
      lock_reg <= rtc_lock_pkg::RST_LOCK;
    end else if (ctrl1_wr) begin
      if (wr_data_i[rtc_lock_pkg::BIT_LOCK]) begin
        lock_reg <= 1'b1;
      end else if (!lock_reg || window) begin
        lock_reg <= 1'b0;
      end
    end
  end

  // enable follows the lock state seen before the write
  always_ff @(posedge mclk_i) begin
    if (dev_rst) begin
      enable_reg <= rtc_lock_pkg::RST_EN;
    end else if (ctrl1_wr && !lock_reg) begin
      enable_reg <= wr_data_i[rtc_lock_pkg::BIT_EN];
    end
  end

  // one storage word per directly mapped address
  genvar i;
  generate
    for (i = 1; i <= 11; i++) begin : g_val
      localparam logic [3:0] ADDR = 4'(i);
      localparam logic GUARDED = (i <= 6);
      always_ff @(posedge mclk_i) begin
        if (dev_rst) begin
          val_reg[i] <= rtc_lock_pkg::RST_VALUE;
        end else if (wr_en_i && addr_i == ADDR && !(GUARDED && lock_reg)) begin
          val_reg[i] <= wr_data_i;
        end
      end
    end
  endgenerate

  // read data stands for one cycle only; unmapped reads give zero
  always_comb begin
    rd_next = 16'h0000;
    case (addr_i)
      rtc_lock_pkg::A_CTRL1L: begin
        rd_next[rtc_lock_pkg::BIT_EN] = enable_reg;
        rd_next[rtc_lock_pkg::BIT_LOCK] = lock_reg;
      end
      rtc_lock_pkg::A_STAT: begin
        rd_next[rtc_lock_pkg::STAT_ARMED] = armed;
        rd_next[rtc_lock_pkg::STAT_OPEN] = window;
      end
      rtc_lock_pkg::A_KEY: rd_next = 16'h0000;
      default: begin
        if (addr_i >= rtc_lock_pkg::A_CTRL2L && addr_i <= rtc_lock_pkg::A_TSTMD) begin
          rd_next = val_reg[addr_i];
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (dev_rst) begin
      rd_data_o <= 16'h0000;
    end else if (rd_en_i) begin
      rd_data_o <= rd_next;
    end else begin
      rd_data_o <= 16'h0000;
    end
  end

  ref_clock_select u_refsel (
    .mclk_i(mclk_i),
    .rst_i(dev_rst),
    .src_pins_i({powerline_i, low_power_rc_oscillator_i, secondary_oscillator_i}),
    .clock_source_field_i(val_reg[1][1:0]),
    .ref_tick_o(ref_tick_o)
  );

  assign clock_calendar_enable_o = enable_reg;
  assign write_lock_bit_o = lock_reg;
  assign clock_source_field_o = val_reg[1][1:0];

  // software is expected to enable first, then set the lock

  chk_lock_reset: assert property (@(posedge mclk_i)
    dev_rst |=> !write_lock_bit_o)
    else $error("lock not cleared by reset");

  chk_locked_drop: assert property (@(posedge mclk_i) disable iff (dev_rst)
    (wr_en_i && protect_hit && lock_reg) |=> val_reg[$past(addr_i)] == $past(val_reg[addr_i]))
    else $error("guarded register changed while locked");

  chk_unlocked_store: assert property (@(posedge mclk_i) disable iff (dev_rst)
    (wr_en_i && protect_hit && !lock_reg) ##1 rd_en_i && addr_i == $past(addr_i)
    |=> rd_data_o == $past(wr_data_i, 2))
    else $error("unlocked write not stored");

  chk_enable_locked: assert property (@(posedge mclk_i) disable iff (dev_rst)
    (ctrl1_wr && lock_reg) |=> clock_calendar_enable_o == $past(clock_calendar_enable_o))
    else $error("enable changed while locked");

  chk_alarm_free: assert property (@(posedge mclk_i) disable iff (dev_rst)
    (wr_en_i && addr_i >= rtc_lock_pkg::A_ALRMT && addr_i <= rtc_lock_pkg::A_TSTMD)
    |=> val_reg[$past(addr_i)] == $past(wr_data_i))
    else $error("free register write lost");

  chk_plain_set: assert property (@(posedge mclk_i) disable iff (dev_rst)
    (ctrl1_wr && wr_data_i[rtc_lock_pkg::BIT_LOCK]) |=> write_lock_bit_o)
    else $error("plain lock set ignored");

  chk_clear_needs_key: assert property (@(posedge mclk_i) disable iff (dev_rst)
    (ctrl1_wr && lock_reg && !window) |=> write_lock_bit_o)
    else $error("lock cleared without key");

  chk_clear_in_window: assert property (@(posedge mclk_i) disable iff (dev_rst)
    (key_wr && wr_data_i[7:0] == rtc_lock_pkg::KEY_FIRST)
    ##1 (key_wr && wr_data_i[7:0] == rtc_lock_pkg::KEY_SECOND)
    ##1 (ctrl1_wr && !wr_data_i[rtc_lock_pkg::BIT_LOCK])
    |=> !write_lock_bit_o)
    else $error("keyed clear not honoured");

  chk_late_clear: assert property (@(posedge mclk_i) disable iff (dev_rst)
    (key_wr && wr_data_i[7:0] == rtc_lock_pkg::KEY_SECOND && armed)
    ##1 (!wr_en_i && lock_reg) ##1 ctrl1_wr |=> write_lock_bit_o)
    else $error("clear honoured after window closed");

  chk_direct_read: assert property (@(posedge mclk_i) disable iff (dev_rst)
    (rd_en_i && addr_i >= rtc_lock_pkg::A_TIMEL && addr_i <= rtc_lock_pkg::A_ALRMD && !wr_en_i)
    |=> rd_data_o == $past(val_reg[addr_i]))
    else $error("direct read mismatch");

  chk_read_one_cycle: assert property (@(posedge mclk_i) disable iff (dev_rst)
    !rd_en_i |=> rd_data_o == 16'h0000)
    else $error("read data held too long");
endmodule : rtc_write_lock_clock_select

// ---- test/testbench.sv ----
// self-checking bench for the clock-calendar write lock and clock source block
// assumes the design package is compiled first; bench drives every port itself
`timescale 1ns/10ps
module testbench;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic brownout_reset_i = 1'b0;
  logic master_clear_reset_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wr_data_i = 16'h0000;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic [2:0] pins = 3'h0;
  logic [15:0] rd_data_o;
  logic clock_calendar_enable_o;
  logic write_lock_bit_o;
  logic ref_tick_o;
  logic [1:0] clock_source_field_o;
  integer n_mismatch = 0;
  integer samples_checked = 0;
  integer seed = 32'h5da2;
  integer op = 0;
  integer win_op = -1;
  integer ticks = 0;
  bit m_lock, m_en, m_armed, rd_pend, live, counting;
  logic [15:0] m_mem [0:15];
  logic [15:0] rd_exp;

  rtc_write_lock_clock_select u_rtc_write_lock_clock_select (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .brownout_reset_i(brownout_reset_i), .master_clear_reset_i(master_clear_reset_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .secondary_oscillator_i(pins[0]), .low_power_rc_oscillator_i(pins[1]), .powerline_i(pins[2]),
    .clock_calendar_enable_o(clock_calendar_enable_o), .write_lock_bit_o(write_lock_bit_o),
    .clock_source_field_o(clock_source_field_o), .ref_tick_o(ref_tick_o));

  initial begin
    forever #10 mclk_i = ~mclk_i;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // every edge passes through here so the unlock window can be counted in bus cycles
  task automatic step();
    @(posedge mclk_i);
    op++;
  endtask : step

  function automatic void model_reset();
    m_lock = 1'b0;
    m_en = 1'b0;
    m_armed = 1'b0;
    win_op = -1;
    rd_pend = 1'b0;
    foreach (m_mem[i]) m_mem[i] = 16'h0000;
  endfunction : model_reset

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bit win;
    wr_en_i <= 1'b1;
    rd_en_i <= 1'b0;
    addr_i <= a;
    wr_data_i <= d;
    step();
    win = (op == win_op);
    if (a == rtc_lock_pkg::A_KEY) begin
      if (m_armed && d[7:0] == rtc_lock_pkg::KEY_SECOND) win_op = op + 1;
      m_armed = (d[7:0] == rtc_lock_pkg::KEY_FIRST);
    end else begin
      m_armed = 1'b0;
    end
    if (a == rtc_lock_pkg::A_CTRL1L) begin
      if (!m_lock) m_en = d[15];
      if (d[11]) m_lock = 1'b1;
      else if (win) m_lock = 1'b0;
    end else if (a <= rtc_lock_pkg::A_DATEH) begin
      if (!m_lock) m_mem[a] = d;
    end else if (a <= rtc_lock_pkg::A_TSTMD) begin
      m_mem[a] = d;
    end
  endtask : wr

  task automatic rd(input logic [3:0] a);
    wr_en_i <= 1'b0;
    rd_en_i <= 1'b1;
    addr_i <= a;
    step();
    rd_pend = 1'b1;
    rd_exp = (a == rtc_lock_pkg::A_CTRL1L) ? {m_en, 3'h0, m_lock, 11'h000} :
      (a == rtc_lock_pkg::A_STAT) ? {14'h0000, m_armed, (op == win_op)} :
      (a <= rtc_lock_pkg::A_TSTMD) ? m_mem[a] : 16'h0000;
  endtask : rd

  task automatic idle(input integer n);
    wr_en_i <= 1'b0;
    rd_en_i <= 1'b0;
    repeat (n) step();
  endtask : idle

  task automatic pulse_reset(input integer which);
    wr_en_i <= 1'b0;
    rd_en_i <= 1'b0;
    sys_rst_i <= (which == 0);
    brownout_reset_i <= (which == 1);
    master_clear_reset_i <= (which == 2);
    step();
    model_reset();
    sys_rst_i <= 1'b0;
    brownout_reset_i <= 1'b0;
    master_clear_reset_i <= 1'b0;
    step();
  endtask : pulse_reset

  // pins held six cycles a level so the synchroniser never filters a pulse
  task automatic tick_run(input logic [1:0] f);
    integer rises;
    logic [2:0] lv;
    logic [2:0] prev;
    wr(rtc_lock_pkg::A_CTRL2L, {14'h0000, f});
    pins <= 3'h0;
    idle(10);
    prev = 3'h0;
    rises = 0;
    ticks = 0;
    counting = 1'b1;
    repeat (24) begin
      lv = 3'($random(seed));
      pins <= lv;
      if (f != 2'h3 && lv[f] && !prev[f]) rises++;
      prev = lv;
      idle(6);
    end
    pins <= 3'h0;
    idle(8);
    counting = 1'b0;
    check("ref_tick_o count", 16'(ticks), (f == 2'h3) ? 16'(24 * 6 + 8) : 16'(rises));
  endtask : tick_run

  always @(negedge mclk_i) begin
    if (live) begin
      check("rd_data_o", rd_data_o, rd_pend ? rd_exp : 16'h0000);
      check("write_lock_bit_o", {15'h0000, write_lock_bit_o}, {15'h0000, m_lock});
      check("clock_calendar_enable_o", {15'h0000, clock_calendar_enable_o}, {15'h0000, m_en});
      check("clock_source_field_o", {14'h0000, clock_source_field_o}, {14'h0000, m_mem[1][1:0]});
      rd_pend = 1'b0;
      if (counting && ref_tick_o === 1'b1) ticks++;
    end
  end

  initial begin
    model_reset();
    repeat (2) step();
    sys_rst_i <= 1'b0;
    live = 1'b1;
    for (int a = 0; a < 16; a++) rd(4'(a));
    for (int a = 0; a < 16; a++) begin
      if (a != 13) wr(4'(a), 16'($random(seed)) & (a == 0 ? 16'hf7ff : a == 1 ? 16'h0003 : 16'hffff));
    end
    for (int a = 0; a < 16; a++) rd(4'(a));
    wr(rtc_lock_pkg::A_CTRL1L, 16'h8000);
    wr(rtc_lock_pkg::A_CTRL1L, 16'h8800);
    for (int a = 0; a < 12; a++) wr(4'(a), 16'($random(seed)) & (a == 0 ? 16'h77ff : 16'hffff));
    for (int a = 0; a < 12; a++) rd(4'(a));
    // variants: plain, gap, other write, read, rearm, late clear, read before clear, wrong byte
    for (int v = 0; v < 8; v++) begin
      wr(rtc_lock_pkg::A_CTRL1L, 16'h8800);
      wr(rtc_lock_pkg::A_KEY, {8'($random(seed)), rtc_lock_pkg::KEY_FIRST});
      if (v == 1) idle(1);
      if (v == 2) wr(rtc_lock_pkg::A_TIMEL, 16'($random(seed)));
      if (v == 3) rd(rtc_lock_pkg::A_STAT);
      if (v == 4) wr(rtc_lock_pkg::A_KEY, 16'h0055);
      wr(rtc_lock_pkg::A_KEY, (v == 7) ? 16'h005a : {8'($random(seed)), rtc_lock_pkg::KEY_SECOND});
      if (v == 5) idle(1);
      if (v == 6) rd(rtc_lock_pkg::A_STAT);
      wr(rtc_lock_pkg::A_CTRL1L, 16'h0000);
      rd(rtc_lock_pkg::A_CTRL1L);
    end
    for (int w = 0; w < 3; w++) begin
      wr(rtc_lock_pkg::A_ALRMT, 16'($random(seed)));
      wr(rtc_lock_pkg::A_CTRL1L, 16'h8800);
      pulse_reset(w);
      rd(rtc_lock_pkg::A_CTRL1L);
      rd(rtc_lock_pkg::A_ALRMT);
    end
    for (int f = 0; f < 4; f++) tick_run(2'(f));
    wr(rtc_lock_pkg::A_TIMEL, 16'($random(seed)));
    rd(rtc_lock_pkg::A_TIMEL);
    idle(2);
    stop_test();
  end

  // whole sequence needs about eight hundred cycles; five thousand is ample
  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end
endmodule : testbench
